//--- logic/ptc_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Each port keeps the egress time of its last sent Delay_Req as seconds and nanoseconds in two read-only registers.
// - The kept Delay_Req egress time of a port is the value handed out for insertion into received Delay_Resp messages.
// - The kept Delay_Req seconds use only bits 3:0, bits 31:4 read as zero, and reset to zero.
// - The kept Delay_Req nanoseconds are a 30-bit read-only field in bits 29:0, reset to zero, bits 31:30 read as zero.
// - A 16-bit read-write upper-seconds field, reset to zero, supplies the top 16 seconds bits for one-step Sync insertion.
// - One upper-seconds value serves all ports.
// - A set falling-edge lock bit keeps a new falling-edge capture from overwriting while that input's flag is pending; locks reset to one.
// - A set rising-edge lock bit keeps a new rising-edge capture from overwriting while that input's flag is pending; locks reset to one.
// - With its falling enable set, a falling edge on an input captures the clock and sets that input's flag; enables reset to zero.
// - With its rising enable set, a rising edge on an input captures the clock and sets that input's flag; enables reset to zero.
// - Edge capture is provided on exactly eight inputs, each with its own enable and lock bits.
// - Port and input registers share one address space, chosen by a 3-bit bank field, a 2-bit port field and a 3-bit input field.
// - Eight rising and eight falling status bits show that a capture timestamp is available.
//////////////////////////////////////////////////////////////////////////////
package ptc_pkg;

   localparam int ADDR_W    = 9;
   localparam int DATA_W    = 32;
   localparam int NUM_GPIO  = 8;
   localparam int NUM_PORT  = 4;
   localparam int SEC_W     = 32;
   localparam int NS_W      = 30;
   localparam int DSEC_W    = 4;
   localparam int UPPER_W   = 16;
   localparam int BANK_W    = 3;
   localparam int PSEL_W    = 2;
   localparam int GSEL_W    = 3;

   // Byte offsets
   localparam logic [8:0] OFS_BANK_SEL     = 9'h104;
   localparam logic [8:0] OFS_IRQ_STATUS   = 9'h108;
   localparam logic [8:0] OFS_IRQ_MASK     = 9'h10C;
   localparam logic [8:0] OFS_CAP_CONFIG   = 9'h15C;
   localparam logic [8:0] OFS_RISE_SEC     = 9'h16C;
   localparam logic [8:0] OFS_RISE_NS      = 9'h170;
   localparam logic [8:0] OFS_FALL_SEC     = 9'h178;
   localparam logic [8:0] OFS_FALL_NS      = 9'h17C;
   localparam logic [8:0] OFS_DREQ_SEC     = 9'h178;
   localparam logic [8:0] OFS_DREQ_NS      = 9'h17C;
   localparam logic [8:0] OFS_SYNC_UPPER   = 9'h180;

   localparam logic [2:0] BANK_PORT = 3'h2;
   localparam logic [2:0] BANK_GPIO = 3'h3;

   // Field positions
   localparam int SEL_BANK_LSB  = 0;
   localparam int SEL_PORT_LSB  = 4;
   localparam int SEL_GPIO_LSB  = 8;
   localparam int CFG_RISE_EN   = 0;
   localparam int CFG_FALL_EN   = 8;
   localparam int CFG_RISE_LOCK = 16;
   localparam int CFG_FALL_LOCK = 24;
   localparam int STS_RISE_LSB  = 0;
   localparam int STS_FALL_LSB  = 8;

   // Reset values
   localparam logic [31:0] CAP_CONFIG_RST = 32'hFFFF_0000;
   localparam logic [15:0] SYNC_UPPER_RST = 16'h0000;
   localparam logic [15:0] IRQ_MASK_RST   = 16'h0000;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int MIN_LEVEL_NS  = 40;
   localparam int MIN_LEVEL_CYC =
      (MIN_LEVEL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic [SEC_W-1:0] sec;
      logic [NS_W-1:0]  ns;
   } ptc_stamp_t;

   typedef struct packed {
      logic [DSEC_W-1:0] sec;
      logic [NS_W-1:0]   ns;
   } ptc_dreq_t;

   localparam int STAMP_W = $bits(ptc_stamp_t);

endpackage

//--- logic/ptc_stamp_mem.sv
`timescale 1ns/100ps
module ptc_stamp_mem
   import ptc_pkg::*;
#(
   parameter int DEPTH = NUM_GPIO,
   parameter int WIDTH = STAMP_W,
   parameter int AW    = $clog2(DEPTH)
)(
   input  wire logic             clk,      // System clock
   input  wire logic             reset,    // Synchronous reset
   input  wire logic [DEPTH-1:0] wr_en,    // One write enable per entry
   input  wire logic [WIDTH-1:0] wr_data,  // Shared write data
   input  wire logic [AW-1:0]    rd_addr,  // Read entry
   output logic      [WIDTH-1:0] rd_data   // Registered read data
);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [WIDTH-1:0] rd_data_reg;

   // All entries written in a cycle share one sample of the clock
   always_ff @(posedge clk) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (reset) begin
            mem_reg[i] <= '0;
         end else if (wr_en[i]) begin
            mem_reg[i] <= wr_data;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data_reg <= '0;
      end else begin
         rd_data_reg <= mem_reg[rd_addr];
      end
   end

   assign rd_data = rd_data_reg;

endmodule

//--- logic/ptc_top.sv
`timescale 1ns/100ps
module ptc_top
   import ptc_pkg::*;
(
   input  wire logic                clk,            // 100 MHz clock
   input  wire logic                reset,          // Synchronous reset
   input  wire logic [ADDR_W-1:0]   bus_addr,       // Register byte address
   input  wire logic [DATA_W-1:0]   bus_wdata,      // Write data
   input  wire logic                bus_wr,         // Write strobe
   input  wire logic                bus_rd,         // Read strobe
   output logic      [DATA_W-1:0]   bus_rdata,      // Read data, next cycle
   input  wire ptc_stamp_t          ptp_time,       // Running clock value
   input  wire logic                dreq_sent,      // Delay_Req egress pulse
   input  wire logic [PSEL_W-1:0]   dreq_port,      // Port of that egress
   input  wire logic [PSEL_W-1:0]   dresp_port,     // Port being answered
   output ptc_dreq_t                dresp_stamp,    // Stamp for Delay_Resp
   output logic      [UPPER_W-1:0]  sync_upper_sec, // Upper Sync seconds
   input  wire logic [NUM_GPIO-1:0] gpio_pin,       // Capture input pins
   output logic                     irq             // Level interrupt
);

   //////////////////////////////////////////////////////////////////////////
   // Registers

   logic [BANK_W-1:0]   bank_reg;
   logic [PSEL_W-1:0]   port_sel_reg;
   logic [GSEL_W-1:0]   gpio_sel_reg;
   logic [31:0]         cfg_reg;
   logic [UPPER_W-1:0]  sync_upper_reg;
   logic [15:0]         mask_reg;
   logic [15:0]         sts_reg;
   logic [15:0]         sts_next;
   logic                irq_reg;
   logic [DATA_W-1:0]   rdata_reg;
   ptc_dreq_t           dreq_reg [NUM_PORT];
   ptc_dreq_t           dresp_reg;
   logic [NUM_GPIO-1:0] gpio_meta_reg;
   logic [NUM_GPIO-1:0] gpio_sync_reg;
   logic [NUM_GPIO-1:0] gpio_prev_reg;

   //////////////////////////////////////////////////////////////////////////
   // Address decode

   wire in_port_bank = bank_reg == BANK_PORT;
   wire in_gpio_bank = bank_reg == BANK_GPIO;
   wire hit_sel      = bus_addr == OFS_BANK_SEL;
   wire hit_sts      = bus_addr == OFS_IRQ_STATUS;
   wire hit_mask     = bus_addr == OFS_IRQ_MASK;
   wire hit_cfg      = in_gpio_bank && bus_addr == OFS_CAP_CONFIG;
   wire hit_rsec     = in_gpio_bank && bus_addr == OFS_RISE_SEC;
   wire hit_rns      = in_gpio_bank && bus_addr == OFS_RISE_NS;
   wire hit_fsec     = in_gpio_bank && bus_addr == OFS_FALL_SEC;
   wire hit_fns      = in_gpio_bank && bus_addr == OFS_FALL_NS;
   wire hit_dsec     = in_port_bank && bus_addr == OFS_DREQ_SEC;
   wire hit_dns      = in_port_bank && bus_addr == OFS_DREQ_NS;
   wire hit_upper    = in_port_bank && bus_addr == OFS_SYNC_UPPER;

   //////////////////////////////////////////////////////////////////////////
   // Edge detection and capture

   wire [NUM_GPIO-1:0] rise_en   = cfg_reg[CFG_RISE_EN +: NUM_GPIO];
   wire [NUM_GPIO-1:0] fall_en   = cfg_reg[CFG_FALL_EN +: NUM_GPIO];
   wire [NUM_GPIO-1:0] rise_lock = cfg_reg[CFG_RISE_LOCK +: NUM_GPIO];
   wire [NUM_GPIO-1:0] fall_lock = cfg_reg[CFG_FALL_LOCK +: NUM_GPIO];
   wire [NUM_GPIO-1:0] sts_rise  = sts_reg[STS_RISE_LSB +: NUM_GPIO];
   wire [NUM_GPIO-1:0] sts_fall  = sts_reg[STS_FALL_LSB +: NUM_GPIO];

   wire [NUM_GPIO-1:0] rise_edge = gpio_sync_reg & ~gpio_prev_reg;
   wire [NUM_GPIO-1:0] fall_edge = ~gpio_sync_reg & gpio_prev_reg;
   wire [NUM_GPIO-1:0] rise_hit  = rise_edge & rise_en;
   wire [NUM_GPIO-1:0] fall_hit  = fall_edge & fall_en;
   // A locked, still-pending capture keeps its first timestamp
   wire [NUM_GPIO-1:0] rise_wr   = rise_hit & ~(rise_lock & sts_rise);
   wire [NUM_GPIO-1:0] fall_wr   = fall_hit & ~(fall_lock & sts_fall);

   // Pins cross into the clock domain through two flops before any use
   always_ff @(posedge clk) begin
      if (reset) begin
         gpio_meta_reg <= '0;
         gpio_sync_reg <= '0;
         gpio_prev_reg <= '0;
      end else begin
         gpio_meta_reg <= gpio_pin;
         gpio_sync_reg <= gpio_meta_reg;
         gpio_prev_reg <= gpio_sync_reg;
      end
   end

   ptc_stamp_t rise_rd;
   ptc_stamp_t fall_rd;

   // One shared sample of ptp_time feeds both seconds and nanoseconds
   ptc_stamp_mem #(.DEPTH(NUM_GPIO), .WIDTH(STAMP_W)) rise_mem (
      .clk     (clk),
      .reset   (reset),
      .wr_en   (rise_wr),
      .wr_data (ptp_time),
      .rd_addr (gpio_sel_reg),
      .rd_data (rise_rd)
   );

   ptc_stamp_mem #(.DEPTH(NUM_GPIO), .WIDTH(STAMP_W)) fall_mem (
      .clk     (clk),
      .reset   (reset),
      .wr_en   (fall_wr),
      .wr_data (ptp_time),
      .rd_addr (gpio_sel_reg),
      .rd_data (fall_rd)
   );

   //////////////////////////////////////////////////////////////////////////
   // Status and interrupt

   wire        sts_rd  = bus_rd && hit_sts;
   wire [15:0] sts_set = {fall_hit, rise_hit};
   // A capture in the clearing read's cycle survives the clear
   assign sts_next = (sts_rd ? 16'h0000 : sts_reg) | sts_set;

   always_ff @(posedge clk) begin
      if (reset) begin
         sts_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         sts_reg <= sts_next;
         irq_reg <= |(sts_next & mask_reg);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Delay_Req egress store

   wire ptc_dreq_t dreq_new = '{sec: ptp_time.sec[DSEC_W-1:0],
                                ns:  ptp_time.ns};

   always_ff @(posedge clk) begin
      for (int p = 0; p < NUM_PORT; p++) begin
         if (reset) begin
            dreq_reg[p] <= '0;
         end else if (dreq_sent && dreq_port == PSEL_W'(p)) begin
            dreq_reg[p] <= dreq_new;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         dresp_reg <= '0;
      end else begin
         dresp_reg <= dreq_reg[dresp_port];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Register writes

   always_ff @(posedge clk) begin
      if (reset) begin
         bank_reg     <= '0;
         port_sel_reg <= '0;
         gpio_sel_reg <= '0;
      end else if (bus_wr && hit_sel) begin
         bank_reg     <= bus_wdata[SEL_BANK_LSB +: BANK_W];
         port_sel_reg <= bus_wdata[SEL_PORT_LSB +: PSEL_W];
         gpio_sel_reg <= bus_wdata[SEL_GPIO_LSB +: GSEL_W];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cfg_reg <= CAP_CONFIG_RST;
      end else if (bus_wr && hit_cfg) begin
         cfg_reg <= bus_wdata;
      end
   end

   // Single copy for every port; never advanced by the block itself
   always_ff @(posedge clk) begin
      if (reset) begin
         sync_upper_reg <= SYNC_UPPER_RST;
      end else if (bus_wr && hit_upper) begin
         sync_upper_reg <= bus_wdata[UPPER_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         mask_reg <= IRQ_MASK_RST;
      end else if (bus_wr && hit_mask) begin
         mask_reg <= bus_wdata[15:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Read path

   ptc_dreq_t cur_dreq;
   assign cur_dreq = dreq_reg[port_sel_reg];
   wire [DSEC_W-1:0] cur_dsec = cur_dreq.sec;
   wire [NS_W-1:0]   cur_dns  = cur_dreq.ns;

   wire [DATA_W-1:0] sel_val = {21'h00_0000, gpio_sel_reg, 2'b00,
                                port_sel_reg, 1'b0, bank_reg};

   // Unmapped addresses read as zero
   wire [DATA_W-1:0] rd_value =
      hit_sel   ? sel_val :
      hit_sts   ? {16'h0000, sts_reg} :
      hit_mask  ? {16'h0000, mask_reg} :
      hit_cfg   ? cfg_reg :
      hit_rsec  ? rise_rd.sec :
      hit_rns   ? {2'b00, rise_rd.ns} :
      hit_fsec  ? fall_rd.sec :
      hit_fns   ? {2'b00, fall_rd.ns} :
      hit_dsec  ? {28'h000_0000, cur_dsec} :
      hit_dns   ? {2'b00, cur_dns} :
      hit_upper ? {16'h0000, sync_upper_reg} :
                  32'h0000_0000;

   always_ff @(posedge clk) begin
      if (reset) begin
         rdata_reg <= '0;
      end else if (bus_rd) begin
         rdata_reg <= rd_value;
      end
   end

   assign bus_rdata      = rdata_reg;
   assign dresp_stamp    = dresp_reg;
   assign sync_upper_sec = sync_upper_reg;
   assign irq            = irq_reg;

   //////////////////////////////////////////////////////////////////////////
   // Checks

   chk_dreq_record: assert property (
      @(posedge clk) disable iff (reset)
      dreq_sent |=> dreq_reg[$past(dreq_port)] == $past(dreq_new))
      else $error("Delay_Req egress time not recorded");

   chk_dresp_path: assert property (
      @(posedge clk) disable iff (reset)
      (dreq_sent && dreq_port == dresp_port && $stable(dresp_port))
      ##1 $stable(dresp_port)
      |=> dresp_reg == $past(dreq_new, 2))
      else $error("Delay_Resp stamp differs from recorded egress");

   chk_dsec_reserved: assert property (
      @(posedge clk) disable iff (reset)
      bus_rd && hit_dsec
      |=> bus_rdata[31:4] == 28'h000_0000
          && bus_rdata[3:0] == $past(cur_dsec))
      else $error("Delay_Req seconds read wrong");

   chk_dns_reserved: assert property (
      @(posedge clk) disable iff (reset)
      bus_rd && hit_dns
      |=> bus_rdata[31:30] == 2'b00
          && bus_rdata[29:0] == $past(cur_dns))
      else $error("Delay_Req nanoseconds read wrong");

   chk_upper_write: assert property (
      @(posedge clk) disable iff (reset)
      bus_wr && hit_upper
      |=> sync_upper_sec == 16'($past(bus_wdata)))
      else $error("Upper seconds not written");

   // Watches the stored stamp itself, not the enable that guards it
   chk_fall_lock: assert property (
      @(posedge clk) disable iff (reset)
      fall_lock[gpio_sel_reg] && sts_fall[gpio_sel_reg]
         && fall_edge[gpio_sel_reg]
      |=> fall_mem.mem_reg[$past(gpio_sel_reg)]
          == $past(fall_mem.mem_reg[gpio_sel_reg]))
      else $error("Locked falling capture was overwritten");

   chk_rise_lock: assert property (
      @(posedge clk) disable iff (reset)
      rise_lock[gpio_sel_reg] && sts_rise[gpio_sel_reg]
         && rise_edge[gpio_sel_reg]
      |=> rise_mem.mem_reg[$past(gpio_sel_reg)]
          == $past(rise_mem.mem_reg[gpio_sel_reg]))
      else $error("Locked rising capture was overwritten");

   chk_fall_capture: assert property (
      @(posedge clk) disable iff (reset)
      |fall_hit |=> (sts_fall & $past(fall_hit)) == $past(fall_hit))
      else $error("Falling capture flag not set");

   chk_rise_capture: assert property (
      @(posedge clk) disable iff (reset)
      |rise_hit |=> (sts_rise & $past(rise_hit)) == $past(rise_hit))
      else $error("Rising capture flag not set");

   chk_irq_level: assert property (
      @(posedge clk) disable iff (reset)
      (|(sts_reg & mask_reg)) && !sts_rd |=> irq)
      else $error("Interrupt low with unmasked status set");

endmodule

//--- tb/ptc_top_bench.sv
`timescale 1ns/100ps
module ptc_top_bench;
   import ptc_pkg::*;

   logic                clk;
   logic                reset;
   logic [ADDR_W-1:0]   bus_addr;
   logic [DATA_W-1:0]   bus_wdata;
   logic                bus_wr;
   logic                bus_rd;
   logic [DATA_W-1:0]   bus_rdata;
   ptc_stamp_t          ptp_time;
   logic                dreq_sent;
   logic [PSEL_W-1:0]   dreq_port;
   logic [PSEL_W-1:0]   dresp_port;
   ptc_dreq_t           dresp_stamp;
   logic [UPPER_W-1:0]  sync_upper_sec;
   logic [NUM_GPIO-1:0] gpio_pin;
   logic                irq;
   int                  err_count;
   int                  cmp_count;
   int                  cyc;

   ptc_top dut (
      .clk            (clk),
      .reset          (reset),
      .bus_addr       (bus_addr),
      .bus_wdata      (bus_wdata),
      .bus_wr         (bus_wr),
      .bus_rd         (bus_rd),
      .bus_rdata      (bus_rdata),
      .ptp_time       (ptp_time),
      .dreq_sent      (dreq_sent),
      .dreq_port      (dreq_port),
      .dresp_port     (dresp_port),
      .dresp_stamp    (dresp_stamp),
      .sync_upper_sec (sync_upper_sec),
      .gpio_pin       (gpio_pin),
      .irq            (irq)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   //////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         report_and_stop();
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Each access leaves one idle cycle so no strobe is driven twice at once
   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rchk(input logic [8:0] a, input logic [31:0] e, string n);
      logic [31:0] v;
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1 v = bus_rdata;
      @(posedge clk);
      check(n, v, e);
   endtask

   task automatic sel(input int g, input int p, input int b);
      wr(OFS_BANK_SEL, 32'(g << 8 | p << 4 | b));
   endtask

   function automatic logic [31:0] mk_sec(input int n);
      return 32'hC0DE_0000 + 32'(n);
   endfunction

   function automatic logic [29:0] mk_ns(input int n);
      return 30'h0ACE_0000 + 30'(n);
   endfunction

   function automatic ptc_stamp_t mk(input int n);
      return '{sec: mk_sec(n), ns: mk_ns(n)};
   endfunction

   // Time is held still so the captured value is known exactly
   task automatic pin_set(input int g, input logic v, input ptc_stamp_t t);
      ptp_time    <= t;
      gpio_pin[g] <= v;
      repeat (8) @(posedge clk);
   endtask

   //////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check("upper out", sync_upper_sec, 0);
      check("dresp out", dresp_stamp, 0);
      check("irq", irq, 0);
      sel(0, 0, 3);
      rchk(OFS_CAP_CONFIG, 32'hFFFF_0000, "config");
      sel(0, 0, 2);
      rchk(OFS_DREQ_SEC, 32'h0000_0000, "dreq sec");
      rchk(OFS_DREQ_NS, 32'h0000_0000, "dreq ns");
      rchk(OFS_SYNC_UPPER, 32'h0000_0000, "upper");
      rchk(9'h1F0, 32'h0000_0000, "unmapped");
   endtask

   task automatic t_upper();
      sel(0, 1, 2);
      wr(OFS_SYNC_UPPER, 32'hFFFF_ABCD);
      rchk(OFS_SYNC_UPPER, 32'h0000_ABCD, "upper rw");
      check("upper out", sync_upper_sec, 16'hABCD);
      sel(0, 3, 2);
      rchk(OFS_BANK_SEL, 32'h0000_0032, "port select");
      rchk(OFS_SYNC_UPPER, 32'h0000_ABCD, "upper shared");
   endtask

   task automatic t_dreq();
      ptc_stamp_t t;
      // Back-to-back egress events, one per port
      for (int p = 0; p < 4; p++) begin
         dreq_sent <= 1'b1;
         dreq_port <= 2'(p);
         ptp_time  <= mk(p * 3 + 1);
         @(posedge clk);
      end
      dreq_sent <= 1'b0;
      @(posedge clk);
      for (int p = 0; p < 4; p++) begin
         t = mk(p * 3 + 1);
         sel(0, p, 2);
         rchk(OFS_DREQ_SEC, {28'h0, t.sec[3:0]}, "dreq sec");
         rchk(OFS_DREQ_NS, {2'b00, t.ns}, "dreq ns");
         dresp_port <= 2'(p);
         repeat (2) @(posedge clk);
         check("dresp", dresp_stamp, {t.sec[3:0], t.ns});
      end
      wr(OFS_DREQ_SEC, 32'hFFFF_FFFF);
      rchk(OFS_DREQ_SEC, {28'h0, t.sec[3:0]}, "dreq ro");
      sel(0, 3, 0);
      rchk(OFS_DREQ_SEC, 32'h0000_0000, "bank miss");
   endtask

   task automatic t_capture();
      wr(OFS_IRQ_MASK, 32'h0000_FFFF);
      rchk(OFS_IRQ_MASK, 32'h0000_FFFF, "mask");
      sel(2, 0, 3);
      rchk(OFS_BANK_SEL, 32'h0000_0203, "gpio select");
      wr(OFS_CAP_CONFIG, 32'hFFFF_2004);
      pin_set(2, 1'b1, mk(40));
      check("irq rise", irq, 1);
      pin_set(2, 1'b0, mk(41));
      pin_set(2, 1'b1, mk(42));
      rchk(OFS_IRQ_STATUS, 32'h0000_0004, "status rise");
      check("irq clear", irq, 0);
      rchk(OFS_RISE_SEC, mk_sec(40), "rise sec lock");
      rchk(OFS_RISE_NS, {2'b00, mk_ns(40)}, "rise ns lock");
      // Rise lock off: a pending flag no longer protects the stamp
      wr(OFS_CAP_CONFIG, 32'hFF00_2004);
      pin_set(2, 1'b0, mk(43));
      pin_set(2, 1'b1, mk(44));
      pin_set(2, 1'b0, mk(45));
      pin_set(2, 1'b1, mk(46));
      rchk(OFS_RISE_SEC, mk_sec(46), "rise sec open");
      rchk(OFS_IRQ_STATUS, 32'h0000_0004, "status rise");
      sel(5, 0, 3);
      pin_set(5, 1'b0, mk(50));
      check("irq fall", irq, 1);
      pin_set(5, 1'b1, mk(51));
      pin_set(5, 1'b0, mk(52));
      rchk(OFS_FALL_SEC, mk_sec(50), "fall sec lock");
      rchk(OFS_FALL_NS, {2'b00, mk_ns(50)}, "fall ns lock");
      rchk(OFS_IRQ_STATUS, 32'h0000_2000, "status fall");
      wr(OFS_CAP_CONFIG, 32'h00FF_2004);
      pin_set(5, 1'b1, mk(53));
      pin_set(5, 1'b0, mk(54));
      pin_set(5, 1'b1, mk(55));
      pin_set(5, 1'b0, mk(56));
      rchk(OFS_FALL_SEC, mk_sec(56), "fall sec open");
      rchk(OFS_FALL_NS, {2'b00, mk_ns(56)}, "fall ns open");
      rchk(OFS_IRQ_STATUS, 32'h0000_2000, "status fall");
      // Masked flag must not reach the interrupt line
      wr(OFS_IRQ_MASK, 32'h0000_0000);
      pin_set(2, 1'b0, mk(60));
      pin_set(2, 1'b1, mk(61));
      check("irq masked", irq, 0);
      rchk(OFS_IRQ_STATUS, 32'h0000_0004, "status masked");
   endtask

   //////////////////////////////////////////////////////////////////////////
   initial begin
      err_count  = 0;
      cmp_count  = 0;
      cyc        = 0;
      reset      = 1'b1;
      bus_addr   = '0;
      bus_wdata  = '0;
      bus_wr     = 1'b0;
      bus_rd     = 1'b0;
      ptp_time   = '0;
      dreq_sent  = 1'b0;
      dreq_port  = '0;
      dresp_port = '0;
      // Capture pins are inputs only; the bench alone drives them
      gpio_pin   = 8'h20;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_reset();
      t_upper();
      t_dreq();
      t_capture();
      report_and_stop();
   end

endmodule
